// ===== logic/status_bank_regs.svh
// Register offsets, field positions and bus constants for the radio status bank.
`ifndef STATUS_BANK_REGS_SVH
`define STATUS_BANK_REGS_SVH

`define ADDR_W                 6
`define OFF_WAKE_TIMER_HIGH    6'h36
`define OFF_WAKE_TIMER_LOW     6'h37
`define OFF_PACKET_STATUS      6'h38
`define OFF_PLL_CAL_SETTING    6'h39
`define OFF_TX_QUEUE_LEVEL     6'h3A
`define OFF_RX_QUEUE_LEVEL     6'h3B
`define OFF_RC_CAL_HIGH        6'h3C
`define OFF_RC_CAL_LOW         6'h3D

`define BIT_CRC_OK             7
`define BIT_CARRIER_SENSE      6
`define BIT_PREAMBLE_QUALITY   5
`define BIT_CHANNEL_CLEAR      4
`define BIT_SYNC_FOUND         3
`define BIT_PIN2_LEVEL         2
`define BIT_PKT_RESERVED       1
`define BIT_PIN0_LEVEL         0
`define BIT_QUEUE_FLAG         7

`define QUEUE_COUNT_W          7
`define RC_RESULT_W            7
`define BYTE_ZERO              8'h00
`define WORD_ZERO              16'h0000
`define SYNC_ZERO              2'h0

`endif

// ===== logic/status_bank_pkg.sv
// Types shared by the radio status bank modules.
package status_bank_pkg;

	typedef logic [7:0] byte_t;
	typedef logic [15:0] word_t;

	typedef enum logic [0:0]
	{
		CRC_CLEAR,
		CRC_MATCHED
	} crc_state_t;

endpackage

// ===== logic/level_sync.sv
// Two-flop synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ns
`include "status_bank_regs.svh"

module level_sync
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset.
	input  wire logic             clock,
	input  wire logic             rst_n,
	// Levels.
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge clock or negedge rst_n)
			begin
				if (!rst_n)
				begin
					meta_q[i]   <= 1'b0;
					sync_out[i] <= 1'b0;
				end
				else
				begin
					meta_q[i]   <= async_in[i];
					sync_out[i] <= meta_q[i];
				end
			end
		end
	endgenerate

endmodule

// ===== logic/crc_flag.sv
// Sticky CRC-match flag, cleared when receive mode starts or restarts unless a check finishes in that cycle.
`timescale 1ns/1ns
`include "status_bank_regs.svh"

module crc_flag
	import status_bank_pkg::*;
(
	// Clock and reset.
	input  wire logic clock,
	input  wire logic rst_n,
	// Events from the packet engine.
	input  wire logic crc_check_done,
	input  wire logic crc_check_match,
	input  wire logic rx_mode_enter,
	// Flag.
	output logic      crc_ok
);

	crc_state_t state_q;
	crc_state_t state_d;

	// A check finishing in the same cycle as a receive restart wins, so the
	// result of that packet is not lost.
	always_comb
	begin
		state_d = state_q;
		if (rx_mode_enter)
			state_d = CRC_CLEAR;
		if (crc_check_done)
			state_d = crc_check_match ? CRC_MATCHED : CRC_CLEAR;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			state_q <= CRC_CLEAR;
		else
			state_q <= state_d;
	end

	assign crc_ok = (state_q == CRC_MATCHED);

endmodule

// ===== logic/radio_status_register_bank.sv
// Read-only status register bank of the sub-GHz radio, read by the host.
//
// Overview of operation
// - Wake timer exposed as high, low bytes.
// - CRC match bit, cleared on receive entry unless a check finishes in that cycle.
// - Live carrier, preamble, clear, sync flags.
// - Pin 2 level read before inversion.
// - Pin 0 level read before inversion.
// - Transmit count in 6:0, underrun bit 7.
// - Receive count low bits, overrun bit 7.
// - RC calibration results, bit 7 zero.
// - PLL calibration setting readable for test.
`timescale 1ns/1ns
`include "status_bank_regs.svh"

module radio_status_register_bank
	import status_bank_pkg::*;
(
	// Clock and reset.
	input  wire logic                      clock,
	input  wire logic                      rst_n,
	// Register port.
	input  wire logic [`ADDR_W-1:0]        reg_addr,
	input  wire logic [7:0]                reg_wdata,
	input  wire logic                      reg_write,
	input  wire logic                      reg_read,
	output byte_t                          reg_rdata,
	// Wake-up timer, same clock.
	input  wire logic [15:0]               wake_timer_value,
	// Packet engine, same clock.
	input  wire logic                      crc_check_done,
	input  wire logic                      crc_check_match,
	input  wire logic                      rx_mode_enter,
	input  wire logic                      carrier_sense,
	input  wire logic                      preamble_quality_flag,
	input  wire logic                      channel_clear_flag,
	input  wire logic                      sync_found_flag,
	// General output pins, before inversion, asynchronous to clock.
	input  wire logic                      general_out_pin_2,
	input  wire logic                      general_out_pin_0,
	// PLL calibration, same clock.
	input  wire logic [7:0]                pll_cal_setting,
	// Queues, same clock.
	input  wire logic [`QUEUE_COUNT_W-1:0] tx_queue_count,
	input  wire logic                      tx_queue_underrun,
	input  wire logic [`QUEUE_COUNT_W-1:0] rx_queue_count,
	input  wire logic                      rx_queue_overrun,
	// RC oscillator calibration, same clock.
	input  wire logic [`RC_RESULT_W-1:0]   rc_cal_result_high,
	input  wire logic [`RC_RESULT_W-1:0]   rc_cal_result_low
);

	logic        crc_ok;
	logic [1:0]  pin_level;
	byte_t       packet_status_flags;
	byte_t       tx_queue_level;
	byte_t       rx_queue_level;
	byte_t       rc_high_byte;
	byte_t       rc_low_byte;
	byte_t       read_value;
	word_t       wake_timer_live;
	byte_t       reg_rdata_d;

	crc_flag u_crc_flag
	(
		.clock           (clock),
		.rst_n           (rst_n),
		.crc_check_done  (crc_check_done),
		.crc_check_match (crc_check_match),
		.rx_mode_enter   (rx_mode_enter),
		.crc_ok          (crc_ok)
	);

	// The pins are taken before the output inverter, so the programmed
	// inversion never shows here. The pin can toggle on its own timing, hence
	// the synchroniser. A lock-indication selection is not reliable through
	// this path; the host is expected not to poll lock this way.
	level_sync
	#(
		.WIDTH (2)
	)
	u_pin_sync
	(
		.clock    (clock),
		.rst_n    (rst_n),
		.async_in ({general_out_pin_2, general_out_pin_0}),
		.sync_out (pin_level)
	);

	assign wake_timer_live = wake_timer_value;

	assign packet_status_flags = {
		crc_ok,
		carrier_sense,
		preamble_quality_flag,
		channel_clear_flag,
		sync_found_flag,
		pin_level[1],
		1'b0,
		pin_level[0]
	};

	assign tx_queue_level = {tx_queue_underrun, tx_queue_count};
	assign rx_queue_level = {rx_queue_overrun, rx_queue_count};
	assign rc_high_byte   = {1'b0, rc_cal_result_high};
	assign rc_low_byte    = {1'b0, rc_cal_result_low};

	function automatic byte_t decode_read
	(
		input logic [`ADDR_W-1:0] addr
	);
		byte_t value;
		value = `BYTE_ZERO;
		unique case (addr)
			`OFF_WAKE_TIMER_HIGH: value = wake_timer_live[15:8];
			`OFF_WAKE_TIMER_LOW:  value = wake_timer_live[7:0];
			`OFF_PACKET_STATUS:   value = packet_status_flags;
			`OFF_PLL_CAL_SETTING: value = pll_cal_setting;
			`OFF_TX_QUEUE_LEVEL:  value = tx_queue_level;
			`OFF_RX_QUEUE_LEVEL:  value = rx_queue_level;
			`OFF_RC_CAL_HIGH:     value = rc_high_byte;
			`OFF_RC_CAL_LOW:      value = rc_low_byte;
			default:              value = `BYTE_ZERO;
		endcase
		return value;
	endfunction

	assign read_value = decode_read(reg_addr);

	// Writes and write data are deliberately unused: every register here is
	// read-only and a read has no side effect.
	assign reg_rdata_d = reg_read ? read_value : `BYTE_ZERO;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= `BYTE_ZERO;
		else
			reg_rdata <= reg_rdata_d;
	end

endmodule

// ===== verif/status_bank_props.sv
// Concurrent checks on the read port of the status bank.
`timescale 1ns/1ns
module status_bank_props
	import status_bank_pkg::*;
(
	// Clock and reset.
	input wire logic        clock,
	input wire logic        rst_n,
	// Register port.
	input wire logic [5:0]  reg_addr,
	input wire logic        reg_read,
	input wire byte_t       reg_rdata,
	// Sources.
	input wire logic [15:0] wake_timer_value,
	input wire logic [7:0]  pll_cal_setting,
	input wire logic [6:0]  tx_queue_count,
	input wire logic        tx_queue_underrun,
	input wire logic [6:0]  rx_queue_count,
	input wire logic        rx_queue_overrun,
	input wire logic [6:0]  rc_cal_result_high,
	input wire logic [6:0]  rc_cal_result_low,
	input wire logic        carrier_sense,
	input wire logic        preamble_quality_flag,
	input wire logic        channel_clear_flag,
	input wire logic        sync_found_flag
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence rd_at(logic [5:0] a);
		reg_read && reg_addr == a;
	endsequence
	a_wake_high: assert property (rd_at(6'h36) |=> reg_rdata == 8'($past(wake_timer_value) >> 8))
		else $error("wake high byte wrong");
	a_wake_low: assert property (rd_at(6'h37) |=> reg_rdata == 8'($past(wake_timer_value)))
		else $error("wake low byte wrong");
	a_pkt_reserved: assert property (rd_at(6'h38) |=> !reg_rdata[1])
		else $error("reserved status bit set");
	a_pll_value: assert property (rd_at(6'h39) |=> reg_rdata == $past(pll_cal_setting))
		else $error("pll setting wrong");
	a_tx_level: assert property (rd_at(6'h3A) |=> reg_rdata == {$past(tx_queue_underrun), $past(tx_queue_count)})
		else $error("tx level wrong");
	a_rx_level: assert property (rd_at(6'h3B) |=> reg_rdata == {$past(rx_queue_overrun), $past(rx_queue_count)})
		else $error("rx level wrong");
	a_rc_low: assert property (rd_at(6'h3D) |=> reg_rdata == {1'b0, $past(rc_cal_result_low)})
		else $error("rc result wrong");
	a_rc_high: assert property (rd_at(6'h3C) |=> reg_rdata == {1'b0, $past(rc_cal_result_high)})
		else $error("rc high result wrong");
	a_pkt_live: assert property (rd_at(6'h38) |=> reg_rdata[6:3] == {$past(carrier_sense),
		$past(preamble_quality_flag), $past(channel_clear_flag), $past(sync_found_flag)})
		else $error("live status flags wrong");
	a_idle_zero: assert property (!reg_read |=> reg_rdata == 8'h00)
		else $error("data outside read");
	c_pkt: cover property (rd_at(6'h38) ##1 reg_rdata[7]);
	c_tx_under: cover property (rd_at(6'h3A) ##1 reg_rdata[7]);
	c_unmapped: cover property (rd_at(6'h3E));
endmodule

bind radio_status_register_bank status_bank_props props (.*);

// ===== verif/host_model.sv
// Host that reads and writes the status bank one strobe at a time.
`timescale 1ns/1ns
module host_model
(
	// Clock.
	input  wire logic       clock,
	// Register port.
	output logic      [5:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_write,
	output logic            reg_read
);
	// The host never treats the pin bits as a lock indication.
	initial {reg_addr, reg_wdata, reg_write, reg_read} = '0;
	task automatic rd(input logic [5:0] a);
		@(posedge clock);
		{reg_addr, reg_read} <= {a, 1'b1};
		@(posedge clock);
		reg_read <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clock);
		{reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the radio status register bank.
`timescale 1ns/1ns
module testbench
	import status_bank_pkg::*;
;
	logic        clock = 0, rst_n = 0, crc_exp = 0, pend = 0;
	logic [5:0]  reg_addr;
	logic [7:0]  reg_wdata, pll_cal_setting;
	logic        reg_write, reg_read, crc_check_done = 0, crc_check_match = 0, rx_mode_enter = 0;
	logic        carrier_sense, preamble_quality_flag, channel_clear_flag, sync_found_flag;
	logic        general_out_pin_2, general_out_pin_0, tx_queue_underrun, rx_queue_overrun;
	logic [15:0] wake_timer_value;
	logic [6:0]  tx_queue_count, rx_queue_count, rc_cal_result_high, rc_cal_result_low;
	byte_t       reg_rdata;
	byte_t       notes[$];
	int          fail_count = 0, total_checks = 0;
	radio_status_register_bank DUT (.*);
	host_model host (.*);
	always #20 clock = ~clock;
	function automatic byte_t exp_of(logic [5:0] a);
		case (a)
			6'h36: return wake_timer_value[15:8];
			6'h37: return wake_timer_value[7:0];
			6'h38: return {crc_exp, carrier_sense, preamble_quality_flag, channel_clear_flag,
				sync_found_flag, general_out_pin_2, 1'b0, general_out_pin_0};
			6'h39: return pll_cal_setting;
			6'h3A: return {tx_queue_underrun, tx_queue_count};
			6'h3B: return {rx_queue_overrun, rx_queue_count};
			6'h3C: return {1'b0, rc_cal_result_high};
			6'h3D: return {1'b0, rc_cal_result_low};
			default: return 8'h00;
		endcase
	endfunction
	task automatic rd(logic [5:0] a);
		notes.push_back(exp_of(a));
		host.rd(a);
	endtask
	task automatic ev(logic d, logic m, logic e);
		@(posedge clock);
		{crc_check_done, crc_check_match, rx_mode_enter} <= {d, m, e};
		@(posedge clock);
		{crc_check_done, rx_mode_enter} <= 2'h0;
		crc_exp = d ? m : (e ? 1'b0 : crc_exp);
	endtask
	task automatic compare_read(byte_t got, byte_t want);
		total_checks++;
		if (got !== want)
		begin
			fail_count++;
			$display("[FAIL] %0t read %h expected %h", $time, got, want);
		end
	endtask
	always @(negedge clock)
	begin
		if (pend)
		begin
			compare_read(reg_rdata, notes[0]);
			void'(notes.pop_front());
		end
		pend = reg_read;
	end
	task automatic print_verdict();
		$display("checks %0d failures %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		void'($urandom(32'h568C));
		for (int i = 0; i < 7; i++)
		begin
			{wake_timer_value, pll_cal_setting, tx_queue_count, rx_queue_count, rc_cal_result_high,
				rc_cal_result_low, tx_queue_underrun, rx_queue_overrun, carrier_sense, preamble_quality_flag,
				channel_clear_flag, sync_found_flag, general_out_pin_2, general_out_pin_0}
				<= 60'({$urandom(), $urandom()});
			repeat (3) @(posedge clock);
			rst_n <= 1'b1;
			host.wr(6'h36, 8'($urandom()));
			for (int a = 'h34; a < 'h3F; a++)
				rd(6'(a));
		end
		ev(1, 1, 0);
		rd(6'h38);
		ev(0, 0, 1);
		rd(6'h38);
		ev(1, 1, 1);
		rd(6'h38);
		ev(1, 0, 0);
		rd(6'h38);
		repeat (3) @(posedge clock);
		print_verdict();
	end
endmodule
